// file: hdl/err_pkg.sv
// Constants, register map and state type of the engine remote request logic
package err_pkg;
  // Timing
  localparam int CLK_KHZ = 200000;
  localparam int SAMPLE_MS = 100;
  localparam int TICK_CYCLES = SAMPLE_MS * CLK_KHZ;
  localparam int STOP_HOLD_MS = 1000;
  localparam logic [3:0] STOP_HOLD_TICKS = 4'(STOP_HOLD_MS / SAMPLE_MS);
  // Sampled input positions
  localparam int N_IN = 16;
  localparam int IN_REM_START = 0;
  localparam int IN_REM_STOP = 1;
  localparam int IN_REP_START = 2;
  localparam int IN_BLACKOUT = 3;
  localparam int IN_PANEL_START = 4;
  localparam int IN_PANEL_STOP = 5;
  localparam int IN_REGEN_INHIB = 6;
  localparam int IN_REGEN_FORCE = 7;
  localparam int IN_BLOCK_A = 8;
  localparam int IN_BLOCK_B = 9;
  localparam int IN_BACKUP_A = 10;
  localparam int IN_BACKUP_B = 11;
  localparam int IN_BACKUP_C = 12;
  localparam int IN_FIRE = 13;
  localparam int IN_CLUTCH = 14;
  localparam int IN_RUNNING = 15;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CRANK = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [7:0] ADDR_SPEED = 8'h0C;
  localparam logic [7:0] ADDR_REQ = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Field positions
  localparam int CTRL_LOCAL = 0;
  localparam int CTRL_OVERRIDE = 1;
  localparam int CTRL_RAMP_LSB = 8;
  localparam int CRANK_ATT_LSB = 0;
  localparam int CRANK_MAX_LSB = 8;
  localparam int CRANK_PAUSE_LSB = 16;
  localparam int TIMER_IDLE_LSB = 0;
  localparam int TIMER_COOL_LSB = 8;
  localparam int SPEED_BACKUP_LSB = 0;
  localparam int SPEED_FIRE_LSB = 16;
  localparam int REQ_VALUE_LSB = 0;
  localparam int REQ_VALID = 16;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_NOT_READY = 4;
  localparam int STAT_CRANK_FAIL = 5;
  localparam int STAT_ATT_LSB = 8;
  localparam int STAT_THR_LSB = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h00000A00;
  localparam logic [31:0] CRANK_RST = 32'h00143203;
  localparam logic [31:0] TIMER_RST = 32'h00006432;
  localparam logic [31:0] SPEED_RST = 32'h032001F4;
  localparam logic [31:0] REQ_RST = 32'h00000000;
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_READY, ST_CRANK, ST_PAUSE, ST_IDLE, ST_RUNNING, ST_COOLING
  } err_state_type;
endpackage : err_pkg

// file: hdl/err_smp_if.sv
// Sampled input levels and edges passed from the sampler to the controller
`timescale 1ns/1ps
`default_nettype none
interface err_smp_if;
  logic tick;
  logic [err_pkg::N_IN-1:0] level;
  logic [err_pkg::N_IN-1:0] rise;
  modport src (output tick, output level, output rise);
  modport dst (input tick, input level, input rise);
endinterface : err_smp_if
`default_nettype wire

// file: hdl/err_sampler.sv
// Input synchroniser, 100 ms sampling tick and edge detection
`timescale 1ns/1ps
`default_nettype none
module err_sampler #(
  parameter int TICK_CYCLES = err_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Raw contacts
  input wire logic [err_pkg::N_IN-1:0] pins_i,
  // Sampled view
  err_smp_if.src smp
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [err_pkg::N_IN-1:0] sync1_reg;
  logic [err_pkg::N_IN-1:0] sync2_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_i;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
      smp.tick <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
      smp.tick <= (cnt_reg == LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      smp.level <= '0;
      smp.rise <= '0;
    end else if (cnt_reg == LAST) begin
      smp.level <= sync2_reg;
      smp.rise <= sync2_reg & ~smp.level;
    end else begin
      smp.rise <= '0;
    end
  end

  property p_edge_on_tick;
    @(posedge clk_i) disable iff (!rst_b_i) (smp.rise != '0) |-> smp.tick && $stable(smp.level) == 1'b0;
  endproperty
  a_edge_on_tick: assert property (p_edge_on_tick) else $error("edge outside a sampling tick");

  property p_edge_is_change;
    @(posedge clk_i) disable iff (!rst_b_i) smp.tick |-> smp.rise == (smp.level & ~$past(smp.level));
  endproperty
  a_edge_is_change: assert property (p_edge_is_change) else $error("edge does not match two samples");
endmodule : err_sampler
`default_nettype wire

// file: hdl/err_ramp.sv
// Throttle position follower with optional per-tick ramp limit
`timescale 1ns/1ps
`default_nettype none
module err_ramp (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic tick_i,
  input wire logic ramp_en_i,
  input wire logic [7:0] step_i,
  input wire logic [9:0] target_i,
  // Result
  output logic [9:0] throttle_o
);
  logic [9:0] gap;

  assign gap = (throttle_o < target_i) ? target_i - throttle_o : throttle_o - target_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      throttle_o <= '0;
    end else if (!ramp_en_i) begin
      throttle_o <= target_i;
    end else if (tick_i) begin
      if (gap <= {2'b00, step_i}) begin
        throttle_o <= target_i;
      end else if (throttle_o < target_i) begin
        throttle_o <= throttle_o + {2'b00, step_i};
      end else begin
        throttle_o <= throttle_o - {2'b00, step_i};
      end
    end
  end

  property p_ramp_rate;
    @(posedge clk_i) disable iff (!rst_b_i)
      ramp_en_i && tick_i && gap > {2'b00, step_i} |=> (throttle_o - $past(throttle_o) == {2'b00, $past(step_i)})
        || ($past(throttle_o) - throttle_o == {2'b00, $past(step_i)});
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("throttle moved by more than one ramp step");
endmodule : err_ramp
`default_nettype wire

// file: hdl/err_ctrl.sv
// Engine remote request logic: start/stop requests, blocking, speed select, clutch, APB registers
// Behaviour
// - first stop edge cools, second stops
// - remote stop ignored in local mode
// - remote stop equals panel stop
// - inputs sampled every 100 ms
// - repetitive start retries to attempt count
// - regeneration inhibit suppresses filter regeneration
// - blackout start edge, remote only, retries
// - remote/panel start give one attempt
// - panel stop accepted after 1 s hold
// - second panel stop skips cooling
// - shutdown override makes repetitive/blackout start attempts unlimited
// - backup speed used when request invalid
// - invalid request without backup gives zero
// - fire speed opens clutch, targets fire speed
// - fire speed approach is ramp limited
// - remote clutch input closes clutch output
// - start blocking ORed forces not ready
// - start blocking also works in local mode
// - second start edge skips idle time
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module err_ctrl #(
  parameter int TICK_CYCLES = err_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Contacts and panel buttons
  input wire logic remote_start_i,
  input wire logic remote_stop_i,
  input wire logic repetitive_remote_start_i,
  input wire logic blackout_start_i,
  input wire logic panel_start_i,
  input wire logic panel_stop_i,
  input wire logic regen_inhibit_i,
  input wire logic regeneration_force_i,
  input wire logic start_block_input_a_i,
  input wire logic start_block_input_b_i,
  input wire logic backup_speed_input_a_i,
  input wire logic backup_speed_input_b_i,
  input wire logic backup_speed_input_c_i,
  input wire logic fire_speed_i,
  input wire logic remote_clutch_i,
  input wire logic engine_running_i,
  // Engine actions
  output logic starter_o,
  output logic fuel_o,
  output logic cooling_o,
  output logic not_ready_o,
  output logic clutch_connect_o,
  output logic regen_inhibit_o,
  output logic [9:0] throttle_position_o
);
  err_smp_if smp ();
  err_pkg::err_state_type state_reg, state_next;
  logic [31:0] ctrl_reg, crank_reg, timer_cfg_reg, speed_reg, req_reg;
  logic [7:0] timer_reg;
  logic [3:0] att_reg, att_next;
  logic multi_reg, multi_next;
  logic [3:0] hold_reg;
  logic panel_stop_evt_reg;
  logic crank_fail_reg;
  logic [9:0] target_reg;
  logic ramp_en_reg;
  logic local_mode, shutdown_override;
  logic start_single, start_multi, stop_evt, blocked, backup_any;
  logic crank_timeout, pause_done, idle_done, cool_done;
  logic [2:0] rd_idx;

  err_sampler #(.TICK_CYCLES(TICK_CYCLES)) u_sampler (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pins_i({engine_running_i, remote_clutch_i, fire_speed_i, backup_speed_input_c_i,
             backup_speed_input_b_i, backup_speed_input_a_i, start_block_input_b_i,
             start_block_input_a_i, regeneration_force_i, regen_inhibit_i, panel_stop_i,
             panel_start_i, blackout_start_i, repetitive_remote_start_i, remote_stop_i,
             remote_start_i}),
    .smp(smp)
  );

  err_ramp u_ramp (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .tick_i(smp.tick),
    .ramp_en_i(ramp_en_reg),
    .step_i(ctrl_reg[err_pkg::CTRL_RAMP_LSB +: 8]),
    .target_i(target_reg),
    .throttle_o(throttle_position_o)
  );

  // Register index from byte address, 7 when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      err_pkg::ADDR_CTRL: reg_index = 3'h0;
      err_pkg::ADDR_CRANK: reg_index = 3'h1;
      err_pkg::ADDR_TIMER: reg_index = 3'h2;
      err_pkg::ADDR_SPEED: reg_index = 3'h3;
      err_pkg::ADDR_REQ: reg_index = 3'h4;
      err_pkg::ADDR_STATUS: reg_index = 3'h5;
      default: reg_index = 3'h7;
    endcase
  endfunction : reg_index

  assign local_mode = ctrl_reg[err_pkg::CTRL_LOCAL];
  assign shutdown_override = ctrl_reg[err_pkg::CTRL_OVERRIDE];
  assign rd_idx = reg_index(paddr);

  // remote requests dead in local mode
  // remote and panel start are single attempt
  assign start_single = (smp.rise[err_pkg::IN_REM_START] & ~local_mode) | smp.rise[err_pkg::IN_PANEL_START];
  assign start_multi = (smp.rise[err_pkg::IN_REP_START] | smp.rise[err_pkg::IN_BLACKOUT]) & ~local_mode;
  // remote stop merges with panel stop
  assign stop_evt = (smp.rise[err_pkg::IN_REM_STOP] & ~local_mode) | panel_stop_evt_reg;
  // blocking inputs ORed, regardless of local mode
  assign blocked = smp.level[err_pkg::IN_BLOCK_A] | smp.level[err_pkg::IN_BLOCK_B];
  assign backup_any = smp.level[err_pkg::IN_BACKUP_A] | smp.level[err_pkg::IN_BACKUP_B]
                    | smp.level[err_pkg::IN_BACKUP_C];

  // Timer limits, compared against whole ticks spent in the state
  assign crank_timeout = timer_reg >= crank_reg[err_pkg::CRANK_MAX_LSB +: 8];
  assign pause_done = timer_reg >= crank_reg[err_pkg::CRANK_PAUSE_LSB +: 8];
  assign idle_done = timer_reg >= timer_cfg_reg[err_pkg::TIMER_IDLE_LSB +: 8];
  assign cool_done = timer_reg >= timer_cfg_reg[err_pkg::TIMER_COOL_LSB +: 8];

  // panel stop counts as an edge only after 1 s hold
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hold_reg <= 4'h0;
      panel_stop_evt_reg <= 1'b0;
    end else if (smp.tick) begin
      if (!smp.level[err_pkg::IN_PANEL_STOP]) begin
        hold_reg <= 4'h0;
      end else if (hold_reg != err_pkg::STOP_HOLD_TICKS) begin
        hold_reg <= hold_reg + 4'h1;
      end
      panel_stop_evt_reg <= smp.level[err_pkg::IN_PANEL_STOP] && (hold_reg == err_pkg::STOP_HOLD_TICKS - 4'h1);
    end else begin
      panel_stop_evt_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    att_next = att_reg;
    multi_next = multi_reg;
    unique case (state_reg)
      err_pkg::ST_NOT_READY: begin
        if (!blocked) state_next = err_pkg::ST_READY;
      end
      err_pkg::ST_READY: begin
        if (blocked) begin
          state_next = err_pkg::ST_NOT_READY;
        end else if (start_multi) begin
          state_next = err_pkg::ST_CRANK;
          att_next = crank_reg[err_pkg::CRANK_ATT_LSB +: 4];
          multi_next = 1'b1;
        end else if (start_single) begin
          state_next = err_pkg::ST_CRANK;
          att_next = 4'h1;
          multi_next = 1'b0;
        end
      end
      err_pkg::ST_CRANK: begin
        if (stop_evt) begin
          state_next = err_pkg::ST_READY;
        end else if (smp.level[err_pkg::IN_RUNNING]) begin
          state_next = err_pkg::ST_IDLE;
        end else if (crank_timeout) begin
          if (multi_reg && (shutdown_override || att_reg > 4'h1)) begin
            state_next = err_pkg::ST_PAUSE;
            if (!shutdown_override) att_next = att_reg - 4'h1;
          end else begin
            state_next = err_pkg::ST_READY;
          end
        end
      end
      err_pkg::ST_PAUSE: begin
        // retry after the pause between cranks
        if (stop_evt) state_next = err_pkg::ST_READY;
        else if (pause_done) state_next = err_pkg::ST_CRANK;
      end
      err_pkg::ST_IDLE: begin
        // stop before cooling is a plain stop
        if (stop_evt) state_next = err_pkg::ST_READY;
        else if (idle_done || start_single) state_next = err_pkg::ST_RUNNING;
      end
      err_pkg::ST_RUNNING: begin
        if (stop_evt) state_next = err_pkg::ST_COOLING;
      end
      err_pkg::ST_COOLING: begin
        if (stop_evt || cool_done) state_next = err_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= err_pkg::ST_NOT_READY;
      att_reg <= 4'h0;
      multi_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      att_reg <= att_next;
      multi_reg <= multi_next;
    end
  end

  // Ticks spent in the current state, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || state_reg != state_next) begin
      timer_reg <= 8'h00;
    end else if (smp.tick && timer_reg != 8'hFF) begin
      timer_reg <= timer_reg + 8'h01;
    end
  end

  // Sticky until the next start, so software sees why cranking ended
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      crank_fail_reg <= 1'b0;
    end else if (state_reg == err_pkg::ST_CRANK && state_next == err_pkg::ST_READY && !stop_evt) begin
      crank_fail_reg <= 1'b1;
    end else if (state_next == err_pkg::ST_CRANK) begin
      crank_fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      starter_o <= 1'b0;
      fuel_o <= 1'b0;
      cooling_o <= 1'b0;
      not_ready_o <= 1'b1;
      clutch_connect_o <= 1'b0;
      regen_inhibit_o <= 1'b0;
    end else begin
      starter_o <= state_reg == err_pkg::ST_CRANK;
      fuel_o <= state_reg inside {err_pkg::ST_CRANK, err_pkg::ST_IDLE, err_pkg::ST_RUNNING, err_pkg::ST_COOLING};
      cooling_o <= state_reg == err_pkg::ST_COOLING;
      not_ready_o <= state_reg == err_pkg::ST_NOT_READY;
      // clutch follows remote clutch, fire opens it
      clutch_connect_o <= smp.level[err_pkg::IN_CLUTCH] & ~smp.level[err_pkg::IN_FIRE];
      regen_inhibit_o <= smp.level[err_pkg::IN_REGEN_INHIB] | smp.level[err_pkg::IN_REGEN_FORCE];
    end
  end

  // Throttle target; only the fire speed approach is ramped
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      target_reg <= 10'h000;
      ramp_en_reg <= 1'b0;
    end else begin
      ramp_en_reg <= smp.level[err_pkg::IN_FIRE];
      if (smp.level[err_pkg::IN_FIRE]) begin
        target_reg <= speed_reg[err_pkg::SPEED_FIRE_LSB +: 10];
      end else if (req_reg[err_pkg::REQ_VALID]) begin
        target_reg <= req_reg[err_pkg::REQ_VALUE_LSB +: 10];
      end else if (backup_any) begin
        target_reg <= speed_reg[err_pkg::SPEED_BACKUP_LSB +: 10];
      end else begin
        target_reg <= 10'h000;
      end
    end
  end

  // APB: one wait state, write applied at the pready edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= rd_idx == 3'h7;
      unique case (rd_idx)
        3'h0: prdata <= ctrl_reg;
        3'h1: prdata <= crank_reg;
        3'h2: prdata <= timer_cfg_reg;
        3'h3: prdata <= speed_reg;
        3'h4: prdata <= req_reg;
        3'h5: prdata <= {6'h00, throttle_position_o, 4'h0, att_reg, 2'h0, crank_fail_reg,
                         state_reg == err_pkg::ST_NOT_READY, 1'b0, state_reg};
        default: prdata <= 32'h00000000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= err_pkg::CTRL_RST;
      crank_reg <= err_pkg::CRANK_RST;
      timer_cfg_reg <= err_pkg::TIMER_RST;
      speed_reg <= err_pkg::SPEED_RST;
      req_reg <= err_pkg::REQ_RST;
    end else if (psel && penable && pready && pwrite) begin
      unique case (reg_index(paddr))
        3'h0: ctrl_reg <= pwdata & 32'h0000FF03;
        3'h1: crank_reg <= pwdata & 32'h00FFFF0F;
        3'h2: timer_cfg_reg <= pwdata & 32'h0000FFFF;
        3'h3: speed_reg <= pwdata & 32'h03FF03FF;
        3'h4: req_reg <= pwdata & 32'h000103FF;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_running_stop;
    state_reg == err_pkg::ST_RUNNING && stop_evt;
  endsequence
  sequence s_cooling_reached;
    state_reg == err_pkg::ST_COOLING ##1 cooling_o;
  endsequence

  property p_first_stop;
    s_running_stop |=> s_cooling_reached;
  endproperty
  a_first_stop: assert property (p_first_stop) else $error("first stop did not start cooling");

  property p_second_stop;
    state_reg == err_pkg::ST_COOLING && stop_evt |=> state_reg == err_pkg::ST_READY ##1 !fuel_o;
  endproperty
  a_second_stop: assert property (p_second_stop) else $error("second stop did not end cooling");

  property p_local_stop;
    local_mode && !panel_stop_evt_reg && (state_reg == err_pkg::ST_RUNNING
      || (state_reg == err_pkg::ST_COOLING && !cool_done)) |=> state_reg == $past(state_reg);
  endproperty
  a_local_stop: assert property (p_local_stop) else $error("remote stop acted in local mode");

  property p_blocked;
    blocked && state_reg == err_pkg::ST_READY |=> state_reg == err_pkg::ST_NOT_READY ##1 not_ready_o;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocking did not force not ready");

  property p_single_attempt;
    state_reg == err_pkg::ST_CRANK && crank_timeout && !multi_reg && !stop_evt
      && !smp.level[err_pkg::IN_RUNNING] |=> state_reg == err_pkg::ST_READY;
  endproperty
  a_single_attempt: assert property (p_single_attempt) else $error("single start cranked again");

  property p_override_retry;
    state_reg == err_pkg::ST_CRANK && crank_timeout && multi_reg && shutdown_override && !stop_evt
      && !smp.level[err_pkg::IN_RUNNING] |=> state_reg == err_pkg::ST_PAUSE && $stable(att_reg);
  endproperty
  a_override_retry: assert property (p_override_retry) else $error("override did not keep retrying");

  property p_zero_throttle;
    !smp.level[err_pkg::IN_FIRE] && !req_reg[err_pkg::REQ_VALID] && !backup_any |=> target_reg == 10'h000;
  endproperty
  a_zero_throttle: assert property (p_zero_throttle) else $error("invalid request left throttle nonzero");

  property p_fire_clutch;
    smp.level[err_pkg::IN_FIRE] |=> !clutch_connect_o && target_reg == $past(speed_reg[err_pkg::SPEED_FIRE_LSB +: 10]);
  endproperty
  a_fire_clutch: assert property (p_fire_clutch) else $error("fire speed kept clutch or wrong target");

  property p_rem_clutch;
    smp.level[err_pkg::IN_CLUTCH] && !smp.level[err_pkg::IN_FIRE] |=> clutch_connect_o;
  endproperty
  a_rem_clutch: assert property (p_rem_clutch) else $error("remote clutch did not close clutch");
endmodule : err_ctrl
`default_nettype wire

// file: tb/err_contacts.sv
// Contact and button model for the engine request inputs
`timescale 1ns/1ps
`default_nettype none
module err_contacts (
  // Clock
  input wire logic clk_i,
  // Contact levels
  output logic [err_pkg::N_IN-1:0] pins_o
);
  initial pins_o = 16'h0000;
  task automatic pulse(input int idx, input int cyc);
    @(posedge clk_i);
    pins_o[idx] <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    pins_o[idx] <= 1'b0;
  endtask : pulse
  task automatic level(input int idx, input logic v);
    @(posedge clk_i);
    pins_o[idx] <= v;
  endtask : level
endmodule : err_contacts
`default_nettype wire

// file: tb/err_ctrl_tb.sv
// Self-checking bench for the engine remote request logic
`timescale 1ns/1ps
`default_nettype none
module err_ctrl_tb;
  localparam int TK = 10;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, starter, fuel, cooling, not_ready, clutch, regen;
  logic [err_pkg::N_IN-1:0] p;
  logic [9:0] thr;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  err_contacts contacts_u (.clk_i(clk), .pins_o(p));
  err_ctrl #(.TICK_CYCLES(TK)) dut_u (.clk_i(clk), .rst_b_i(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_start_i(p[0]), .remote_stop_i(p[1]), .repetitive_remote_start_i(p[2]), .blackout_start_i(p[3]),
    .panel_start_i(p[4]), .panel_stop_i(p[5]), .regen_inhibit_i(p[6]), .regeneration_force_i(p[7]),
    .start_block_input_a_i(p[8]), .start_block_input_b_i(p[9]), .backup_speed_input_a_i(p[10]),
    .backup_speed_input_b_i(p[11]), .backup_speed_input_c_i(p[12]), .fire_speed_i(p[13]),
    .remote_clutch_i(p[14]), .engine_running_i(p[15]), .starter_o(starter), .fuel_o(fuel),
    .cooling_o(cooling), .not_ready_o(not_ready), .clutch_connect_o(clutch), .regen_inhibit_o(regen),
    .throttle_position_o(thr));
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // Idle edge first, so a release never meets a new request in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic lvl(input int idx, input logic v);
    contacts_u.level(idx, v);
    repeat (3 * TK) @(posedge clk);
  endtask : lvl
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, err_pkg::ADDR_CRANK, 32'h0);
    chk(r, err_pkg::CRANK_RST);
    apb(1'b0, 8'h18, 32'h0);
    chk(e, 1'b1);
    $display("registers done");
    contacts_u.pulse(err_pkg::IN_REM_START, 30);
    chk(starter, 1'b1);
    lvl(err_pkg::IN_RUNNING, 1'b1);
    contacts_u.pulse(err_pkg::IN_REM_START, 30);
    apb(1'b0, err_pkg::ADDR_STATUS, 32'h0);
    chk(r[2:0], 3'h5);
    contacts_u.pulse(err_pkg::IN_REM_STOP, 30);
    chk(cooling, 1'b1);
    apb(1'b1, err_pkg::ADDR_CTRL, 32'h00000A01);
    contacts_u.pulse(err_pkg::IN_REM_STOP, 30);
    chk(cooling, 1'b1);
    contacts_u.pulse(err_pkg::IN_PANEL_STOP, 50);
    chk(cooling, 1'b1);
    repeat (3 * TK) @(posedge clk);
    contacts_u.pulse(err_pkg::IN_PANEL_STOP, 120);
    chk({cooling, fuel}, 2'b00);
    $display("start stop done");
    lvl(err_pkg::IN_BLOCK_A, 1'b1);
    chk(not_ready, 1'b1);
    contacts_u.pulse(err_pkg::IN_PANEL_START, 30);
    chk(starter, 1'b0);
    lvl(err_pkg::IN_BLOCK_A, 1'b0);
    $display("blocking done");
    lvl(err_pkg::IN_RUNNING, 1'b0);
    apb(1'b1, err_pkg::ADDR_CRANK, 32'h00010302);
    apb(1'b1, err_pkg::ADDR_CTRL, 32'h00000A00);
    contacts_u.pulse(err_pkg::IN_REP_START, 30);
    repeat (3 * TK) @(posedge clk);
    apb(1'b0, err_pkg::ADDR_STATUS, 32'h0);
    chk(r[11:0], 12'h102);
    repeat (5 * TK) @(posedge clk);
    contacts_u.pulse(err_pkg::IN_REM_START, 30);
    repeat (3 * TK) @(posedge clk);
    apb(1'b0, err_pkg::ADDR_STATUS, 32'h0);
    chk(r[11:0], 12'h121);
    apb(1'b1, err_pkg::ADDR_CTRL, 32'h00000A02);
    contacts_u.pulse(err_pkg::IN_BLACKOUT, 30);
    repeat (3 * TK) @(posedge clk);
    apb(1'b0, err_pkg::ADDR_STATUS, 32'h0);
    chk({r[11:8], r[2:1]}, 6'h09);
    contacts_u.pulse(err_pkg::IN_REM_STOP, 30);
    chk({starter, fuel}, 2'b00);
    $display("cranking done");
    apb(1'b1, err_pkg::ADDR_REQ, 32'h0001012C);
    repeat (3 * TK) @(posedge clk);
    chk(thr, 10'h12C);
    apb(1'b1, err_pkg::ADDR_REQ, 32'h0000012C);
    repeat (3 * TK) @(posedge clk);
    chk(thr, 10'h000);
    lvl(err_pkg::IN_BACKUP_B, 1'b1);
    chk(thr, 10'h1F4);
    lvl(err_pkg::IN_CLUTCH, 1'b1);
    chk(clutch, 1'b1);
    lvl(err_pkg::IN_FIRE, 1'b1);
    chk({clutch, thr < 10'h320}, 2'b01);
    repeat (40 * TK) @(posedge clk);
    chk(thr, 10'h320);
    lvl(err_pkg::IN_REGEN_INHIB, 1'b1);
    chk(regen, 1'b1);
    $display("outputs done");
    finish_test();
  end
endmodule : err_ctrl_tb
`default_nettype wire
